// File: rtl/arj_top.sv
`timescale 1ns/100ps
`default_nettype none
module arj_top (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [arj_pkg::ADDR_W-1:0] addr_in,
  input wire logic [arj_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [arj_pkg::DATA_W-1:0] rdata_out,
  input wire logic [arj_pkg::TRIG_SRC_N-1:0] trig_src_in,
  input wire logic conv_done_in,
  input wire logic [arj_pkg::RESULT_W-1:0] conv_result_in,
  output logic conv_start_out,
  output logic converter_power_on_out,
  output logic result_format_select_out,
  output logic [5:0] input_channel_select_out,
  output logic [2:0] clk_div_sel_out,
  output logic [1:0] ref_sel_out
);
  arj_pkg::arj_top_s s;
  arj_pkg::arj_top_s next_s;
  logic fmt;
  logic go_set;

  arj_trig_if tif ();

  arj_trig_edge u_edge (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .src_in(trig_src_in),
    .tif(tif.edge_det)
  );

  assign tif.sel = s.trig_sel;
  assign fmt = s.ctl1[arj_pkg::CTL1_FMT_BIT];

  always_comb
  begin
    next_s = s;
    go_set = 1'b0;
    next_s.rdata = arj_pkg::RD_ZERO;
    next_s.start = 1'b0;
    if (wr_in)
    begin
      case (addr_in)
        arj_pkg::OFS_CTL0: next_s.ctl0 = wdata_in;
        arj_pkg::OFS_CTL1: next_s.ctl1 = wdata_in & arj_pkg::CTL1_WMASK;
        arj_pkg::OFS_TRIG: next_s.trig_sel = wdata_in[arj_pkg::TRIG_SEL_W-1:0];
        arj_pkg::OFS_RES_HI: next_s.res_hi = wdata_in;
        arj_pkg::OFS_RES_LO: next_s.res_lo = wdata_in;
        default: next_s.rdata = arj_pkg::RD_ZERO;
      endcase
      go_set = (addr_in == arj_pkg::OFS_CTL0) && wdata_in[arj_pkg::CTL0_GO_BIT];
    end
    if (rd_in)
    begin
      case (addr_in)
        arj_pkg::OFS_CTL0: next_s.rdata = s.ctl0;
        arj_pkg::OFS_CTL1: next_s.rdata = s.ctl1;
        arj_pkg::OFS_TRIG: next_s.rdata = {3'h0, s.trig_sel};
        arj_pkg::OFS_RES_HI: next_s.rdata = s.res_hi;
        arj_pkg::OFS_RES_LO: next_s.rdata = s.res_lo;
        default: next_s.rdata = arj_pkg::RD_ZERO;
      endcase
    end
    if (tif.pulse)
    begin
      go_set = 1'b1;
    end
    // Completion clears busy, but a new start in the same cycle wins
    if (conv_done_in)
    begin
      next_s.ctl0[arj_pkg::CTL0_GO_BIT] = 1'b0;
      // Completion beats a software write to the results in the same cycle
      if (fmt == arj_pkg::FMT_RIGHT)
      begin
        next_s.res_hi = {arj_pkg::RSVD6, conv_result_in[9:8]};
        next_s.res_lo = conv_result_in[7:0];
      end
      else
      begin
        next_s.res_hi = conv_result_in[9:2];
        next_s.res_lo = {conv_result_in[1:0], arj_pkg::RSVD6};
      end
    end
    if (go_set && next_s.ctl0[arj_pkg::CTL0_ON_BIT])
    begin
      next_s.ctl0[arj_pkg::CTL0_GO_BIT] = 1'b1;
    end
    else if (!next_s.ctl0[arj_pkg::CTL0_ON_BIT])
    begin
      next_s.ctl0[arj_pkg::CTL0_GO_BIT] = 1'b0;
    end
    next_s.start = next_s.ctl0[arj_pkg::CTL0_GO_BIT] && !s.ctl0[arj_pkg::CTL0_GO_BIT];
  end

  always_ff @(posedge clk_in)
  begin
    // No reset on the results: contents must survive every reset
    s.res_hi <= next_s.res_hi;
    s.res_lo <= next_s.res_lo;
    if (srst_in)
    begin
      s.ctl0 <= arj_pkg::CTL_RST;
      s.ctl1 <= arj_pkg::CTL_RST;
      s.trig_sel <= arj_pkg::TRIG_RST;
      s.rdata <= arj_pkg::RD_ZERO;
      s.start <= 1'b0;
    end
    else
    begin
      s.ctl0 <= next_s.ctl0;
      s.ctl1 <= next_s.ctl1;
      s.trig_sel <= next_s.trig_sel;
      s.rdata <= next_s.rdata;
      s.start <= next_s.start;
    end
  end

  assign rdata_out = s.rdata;
  assign conv_start_out = s.start;
  assign converter_power_on_out = s.ctl0[arj_pkg::CTL0_ON_BIT];
  assign result_format_select_out = fmt;
  assign input_channel_select_out = s.ctl0[arj_pkg::CTL0_CHS_LSB +: 6];
  assign clk_div_sel_out = s.ctl1[arj_pkg::CTL1_CLK_LSB +: 3];
  assign ref_sel_out = s.ctl1[arj_pkg::CTL1_REF_LSB +: 2];

  a_left_high_bits: assert property (@(posedge clk_in)
    conv_done_in && !fmt |=> s.res_hi == $past(conv_result_in[9:2]))
    else $error("left high register wrong");
  a_left_low_bits: assert property (@(posedge clk_in)
    conv_done_in && !fmt |=> s.res_lo[7:6] == $past(conv_result_in[1:0]))
    else $error("left low register wrong");
  a_right_high_bits: assert property (@(posedge clk_in)
    conv_done_in && fmt |=> s.res_hi[1:0] == $past(conv_result_in[9:8]))
    else $error("right high register wrong");
  a_right_low_bits: assert property (@(posedge clk_in)
    conv_done_in && fmt |=> s.res_lo == $past(conv_result_in[7:0]))
    else $error("right low register wrong");
  a_format_picks_layout: assert property (@(posedge clk_in)
    conv_done_in |=> ($past(fmt) ? s.res_hi[7:2] == arj_pkg::RSVD6 : s.res_lo[5:0] == arj_pkg::RSVD6))
    else $error("layout does not follow format bit");
  a_results_kept: assert property (@(posedge clk_in)
    !conv_done_in && !(wr_in && (addr_in == arj_pkg::OFS_RES_HI || addr_in == arj_pkg::OFS_RES_LO))
      |=> $stable(s.res_hi) && $stable(s.res_lo))
    else $error("result changed without cause");
  a_results_readable: assert property (@(posedge clk_in) disable iff (srst_in)
    rd_in && addr_in == arj_pkg::OFS_RES_LO ##1 !srst_in |-> rdata_out == $past(s.res_lo))
    else $error("result low read wrong");
  a_both_loaded: assert property (@(posedge clk_in)
    conv_done_in |=> {s.res_hi, s.res_lo} == ($past(fmt)
      ? {arj_pkg::RSVD6, $past(conv_result_in), 8'h00} >> 8 | {6'h00, $past(conv_result_in)}
      : {$past(conv_result_in), arj_pkg::RSVD6}))
    else $error("results not loaded together");

  // Register bus
  a_read_idle_zero: assert property (@(posedge clk_in)
    !rd_in |=> rdata_out == arj_pkg::RD_ZERO)
    else $error("read data not zero when idle");
  a_read_unmapped_zero: assert property (@(posedge clk_in)
    rd_in && addr_in > arj_pkg::OFS_RES_LO |=> rdata_out == arj_pkg::RD_ZERO)
    else $error("unmapped read not zero");
  a_read_control_zero: assert property (@(posedge clk_in) disable iff (srst_in)
    rd_in && addr_in == arj_pkg::OFS_CTL0 |=> rdata_out == $past(s.ctl0))
    else $error("control zero read wrong");
  a_read_control_one: assert property (@(posedge clk_in) disable iff (srst_in)
    rd_in && addr_in == arj_pkg::OFS_CTL1 |=> rdata_out == $past(s.ctl1))
    else $error("control one read wrong");
  a_read_trigger_select: assert property (@(posedge clk_in) disable iff (srst_in)
    rd_in && addr_in == arj_pkg::OFS_TRIG |=> rdata_out[arj_pkg::TRIG_SEL_W-1:0] == $past(tif.sel)
      && (rdata_out >> arj_pkg::TRIG_SEL_W) == arj_pkg::RD_ZERO)
    else $error("trigger select read wrong");
  a_read_result_high: assert property (@(posedge clk_in) disable iff (srst_in)
    rd_in && addr_in == arj_pkg::OFS_RES_HI ##1 !srst_in |-> rdata_out == $past(s.res_hi))
    else $error("result high read wrong");
  a_write_control_one: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == arj_pkg::OFS_CTL1 |=> s.ctl1 == ($past(wdata_in) & arj_pkg::CTL1_WMASK))
    else $error("control one write wrong");
  a_write_trigger_select: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == arj_pkg::OFS_TRIG |=> tif.sel == $past(wdata_in[arj_pkg::TRIG_SEL_W-1:0]))
    else $error("trigger select write wrong");
  a_write_result_high: assert property (@(posedge clk_in)
    wr_in && addr_in == arj_pkg::OFS_RES_HI && !conv_done_in |=> s.res_hi == $past(wdata_in))
    else $error("result high write lost");
  a_write_result_low: assert property (@(posedge clk_in)
    wr_in && addr_in == arj_pkg::OFS_RES_LO && !conv_done_in |=> s.res_lo == $past(wdata_in))
    else $error("result low write lost");
  a_power_follows_write: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == arj_pkg::OFS_CTL0 |=> converter_power_on_out == $past(wdata_in[arj_pkg::CTL0_ON_BIT]))
    else $error("power bit write wrong");
  a_control_one_gap: assert property (@(posedge clk_in) disable iff (srst_in)
    (s.ctl1 & ~arj_pkg::CTL1_WMASK) == arj_pkg::RD_ZERO)
    else $error("unused control one bits set");
  a_reset_clears_control: assert property (@(posedge clk_in)
    srst_in |=> s.ctl0 == arj_pkg::CTL_RST && s.ctl1 == arj_pkg::CTL_RST && tif.sel == arj_pkg::TRIG_RST
      && !conv_start_out)
    else $error("control not cleared by reset");

  // Start and busy: power off must win over any start
  a_start_one_cycle: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_start_out |=> !conv_start_out)
    else $error("start pulse longer than one cycle");
  a_start_needs_power: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_start_out |-> converter_power_on_out)
    else $error("start while powered down");
  a_busy_needs_power: assert property (@(posedge clk_in) disable iff (srst_in)
    s.ctl0[arj_pkg::CTL0_GO_BIT] |-> s.ctl0[arj_pkg::CTL0_ON_BIT])
    else $error("busy while powered down");
  a_done_clears_busy: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_done_in && !tif.pulse && !(wr_in && addr_in == arj_pkg::OFS_CTL0) |=> !s.ctl0[arj_pkg::CTL0_GO_BIT])
    else $error("busy not cleared by completion");
  a_trigger_starts_conversion: assert property (@(posedge clk_in) disable iff (srst_in)
    tif.pulse && converter_power_on_out && !s.ctl0[arj_pkg::CTL0_GO_BIT]
      && !(wr_in && addr_in == arj_pkg::OFS_CTL0) |=> conv_start_out)
    else $error("trigger edge gave no start");
endmodule
`default_nettype wire

// File: rtl/arj_pkg.sv
package arj_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned TRIG_SEL_W = 5;
  localparam int unsigned TRIG_SRC_N = 32;
  // Register indices
  localparam logic [ADDR_W-1:0] OFS_CTL0 = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTL1 = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_TRIG = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_RES_HI = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_RES_LO = 3'h4;
  // converter_control_zero fields
  localparam int unsigned CTL0_ON_BIT = 0;
  localparam int unsigned CTL0_GO_BIT = 1;
  localparam int unsigned CTL0_CHS_LSB = 2;
  // converter_control_one fields
  localparam int unsigned CTL1_FMT_BIT = 7;
  localparam int unsigned CTL1_CLK_LSB = 4;
  localparam int unsigned CTL1_REF_LSB = 0;
  localparam logic [DATA_W-1:0] CTL1_WMASK = 8'hF3;
  localparam logic [DATA_W-1:0] CTL_RST = 8'h00;
  localparam logic [TRIG_SEL_W-1:0] TRIG_RST = 5'h00;
  localparam logic [TRIG_SEL_W-1:0] TRIG_NONE = 5'h00;
  localparam logic [5:0] RSVD6 = 6'h00;
  localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;
  localparam logic FMT_LEFT = 1'b0;
  localparam logic FMT_RIGHT = 1'b1;

  typedef struct packed {
    logic [DATA_W-1:0] ctl0;
    logic [DATA_W-1:0] ctl1;
    logic [TRIG_SEL_W-1:0] trig_sel;
    logic [DATA_W-1:0] res_hi;
    logic [DATA_W-1:0] res_lo;
    logic [DATA_W-1:0] rdata;
    logic start;
  } arj_top_s;

  typedef struct packed {
    logic [TRIG_SRC_N-1:0] sync1;
    logic [TRIG_SRC_N-1:0] sync2;
    logic prev;
    logic pulse;
  } arj_edge_s;
endpackage

// File: rtl/arj_trig_if.sv
`timescale 1ns/100ps
`default_nettype none
interface arj_trig_if;
  logic [arj_pkg::TRIG_SEL_W-1:0] sel;
  logic pulse;
  modport ctrl (output sel, input pulse);
  modport edge_det (input sel, output pulse);
endinterface
`default_nettype wire

// File: rtl/arj_trig_edge.sv
`timescale 1ns/100ps
`default_nettype none
module arj_trig_edge (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [arj_pkg::TRIG_SRC_N-1:0] src_in,
  arj_trig_if.edge_det tif
);
  arj_pkg::arj_edge_s s;
  arj_pkg::arj_edge_s next_s;
  logic cur;

  always_comb
  begin
    next_s = s;
    cur = s.sync2[tif.sel];
    next_s.sync1 = src_in;
    next_s.sync2 = s.sync1;
    next_s.prev = cur;
    // A low-to-high change of the chosen source, or a move of the selection onto a high source, starts a conversion
    next_s.pulse = (tif.sel != arj_pkg::TRIG_NONE) && cur && !s.prev;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tif.pulse = s.pulse;

  a_trig_rising_edge: assert property (@(posedge clk_in) disable iff (srst_in)
    (tif.pulse |-> $past(s.sync2[tif.sel]) && !$past(s.prev) && tif.sel != arj_pkg::TRIG_NONE)
    or ($past(tif.sel) != tif.sel))
    else $error("trigger pulse without rising edge");
endmodule
`default_nettype wire

// File: dv/adc_result_justify_test.sv
`timescale 1ns/100ps
`default_nettype none
module adc_result_justify_test;
  logic clk_in;
  logic srst_in;
  logic [arj_pkg::ADDR_W-1:0] addr_in;
  logic [arj_pkg::DATA_W-1:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [arj_pkg::DATA_W-1:0] rdata_out;
  logic [arj_pkg::TRIG_SRC_N-1:0] trig_src_in;
  logic conv_done_in;
  logic [arj_pkg::RESULT_W-1:0] conv_result_in;
  logic conv_start_out;
  logic converter_power_on_out;
  logic result_format_select_out;
  logic [5:0] chan_sel;
  logic [2:0] div_sel;
  logic [1:0] ref_sel;
  logic [9:0] r;
  int bad_count;
  int n_compared;
  int n;
  arj_top dut (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .trig_src_in(trig_src_in), .conv_done_in(conv_done_in),
    .conv_result_in(conv_result_in), .conv_start_out(conv_start_out), .converter_power_on_out(converter_power_on_out),
    .result_format_select_out(result_format_select_out), .input_channel_select_out(chan_sel),
    .clk_div_sel_out(div_sel), .ref_sel_out(ref_sel));
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe edge
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 compare(rdata_out, exp);
  endtask
  task automatic chk_bits(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 compare(rdata_out & m, exp);
  endtask
  task automatic finish_conv(input logic [9:0] v);
    @(posedge clk_in);
    conv_done_in <= 1'b1;
    conv_result_in <= v;
    @(posedge clk_in);
    conv_done_in <= 1'b0;
  endtask
  task automatic stop_test();
    $display("Compared %0d, bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    srst_in = 1'b1;
    addr_in = 3'h0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    trig_src_in = 32'h0000_0000;
    // Results have no reset; a zero load during reset gives them a value
    conv_done_in = 1'b1;
    conv_result_in = 10'h000;
    bad_count = 0;
    n_compared = 0;
    @(posedge clk_in);
    conv_done_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    // Both layouts, two patterns with every bit toggling
    for (int f = 0; f < 2; f++)
    begin
      wr_reg(arj_pkg::OFS_CTL1, f ? 8'h80 : 8'h00);
      #1 compare({7'h00, result_format_select_out}, f ? 8'h01 : 8'h00);
      for (int k = 0; k < 2; k++)
      begin
        r = k ? 10'h05a : 10'h3a5;
        finish_conv(r);
        chk_reg(arj_pkg::OFS_RES_HI, f ? {6'h00, r[9:8]} : r[9:2]);
        chk_reg(arj_pkg::OFS_RES_LO, f ? r[7:0] : {r[1:0], 6'h00});
      end
    end
    // Back-to-back completions: the later one must win
    @(posedge clk_in);
    conv_done_in <= 1'b1;
    conv_result_in <= 10'h155;
    @(posedge clk_in);
    conv_result_in <= 10'h2aa;
    @(posedge clk_in);
    conv_done_in <= 1'b0;
    chk_reg(arj_pkg::OFS_RES_HI, 8'h02);
    chk_reg(arj_pkg::OFS_RES_LO, 8'haa);
    // Software looks only at the result bits, never the reserved ones
    wr_reg(arj_pkg::OFS_RES_HI, 8'hfc);
    finish_conv(10'h155);
    chk_bits(arj_pkg::OFS_RES_HI, 8'h03, 8'h01);
    wr_reg(arj_pkg::OFS_CTL1, 8'h00);
    wr_reg(arj_pkg::OFS_RES_LO, 8'h3f);
    finish_conv(10'h2aa);
    chk_bits(arj_pkg::OFS_RES_LO, 8'hc0, 8'h80);
    // Software access, then a reset must leave results alone
    wr_reg(arj_pkg::OFS_RES_HI, 8'h5a);
    wr_reg(arj_pkg::OFS_RES_LO, 8'ha5);
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    chk_reg(arj_pkg::OFS_RES_HI, 8'h5a);
    chk_reg(arj_pkg::OFS_RES_LO, 8'ha5);
    chk_reg(arj_pkg::OFS_CTL1, arj_pkg::CTL_RST);
    // Unused control one bits stay clear; fields reach their outputs
    wr_reg(arj_pkg::OFS_CTL1, 8'hff);
    #1 compare({3'h0, div_sel, ref_sel}, 8'h1f);
    chk_reg(arj_pkg::OFS_CTL1, 8'hf3);
    wr_reg(3'h5, 8'hff);
    chk_reg(3'h5, arj_pkg::RD_ZERO);
    // Software start gives a single pulse
    wr_reg(arj_pkg::OFS_CTL0, 8'hff);
    #1 compare({7'h00, conv_start_out}, 8'h01);
    compare({2'h0, chan_sel}, 8'h3f);
    compare({7'h00, converter_power_on_out}, 8'h01);
    @(posedge clk_in);
    #1 compare({7'h00, conv_start_out}, 8'h00);
    finish_conv(10'h000);
    chk_reg(arj_pkg::OFS_CTL0, 8'hfd);
    // Trigger source 3: a rising edge starts, a held level does not
    wr_reg(arj_pkg::OFS_TRIG, 8'h03);
    repeat (3) @(posedge clk_in);
    trig_src_in <= 32'h0000_0008;
    n = 0;
    while (conv_start_out !== 1'b1 && n < 10)
    begin
      @(posedge clk_in);
      #1 n++;
    end
    compare({7'h00, conv_start_out}, 8'h01);
    finish_conv(10'h000);
    n = 0;
    repeat (8)
    begin
      @(posedge clk_in);
      #1 n += int'(conv_start_out === 1'b1);
    end
    compare(8'(n), 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
